/* File: hdl/wgamc_pkg.sv */
// Purpose: Constants and types for the web guide actuator mode control
// Assumes: 25 MHz core clock, 16-bit register data
// Notes: Byte offsets, one register per word address
package wgamc_pkg;
  localparam int CLK_HZ = 25_000_000;
  localparam int CTRL_PERIOD_US = 1000;
  localparam int CTRL_PERIOD_CYC = CLK_HZ / 1_000_000 * CTRL_PERIOD_US;
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_SETPOS = 8'h04;
  localparam logic [7:0] A_MANPOS = 8'h08;
  localparam logic [7:0] A_MANSPD = 8'h0C;
  localparam logic [7:0] A_AUTSPD = 8'h10;
  localparam logic [7:0] A_SRCSPD = 8'h14;
  localparam logic [7:0] A_CENTER = 8'h18;
  localparam logic [7:0] A_OFFSET = 8'h1C;
  localparam logic [7:0] A_OSCPTH = 8'h20;
  localparam logic [7:0] A_OSCPER = 8'h24;
  localparam logic [7:0] A_SNSRNG = 8'h28;
  localparam logic [7:0] A_BEAMRNG = 8'h2C;
  localparam logic [7:0] A_KPPOS = 8'h30;
  localparam logic [7:0] A_KPSPD = 8'h34;
  localparam logic [7:0] A_KISPD = 8'h38;
  localparam logic [7:0] A_KPACT = 8'h3C;
  localparam logic [7:0] A_STATUS = 8'h40;
  localparam logic [7:0] A_ACTPOS = 8'h44;
  localparam logic [7:0] A_ACTSPD = 8'h48;
  // CTRL fields
  localparam int F_MODE = 0;
  localparam int F_STRUCT = 3;
  localparam int F_FIXED = 5;
  localparam int F_TWOCAR = 6;
  localparam int F_OSC = 7;
  localparam logic [15:0] RST_SPEED = 16'h0100;
  localparam logic [15:0] RST_RANGE = 16'h1000;
  localparam logic [15:0] RST_GAIN = 16'h0100;
  localparam logic [15:0] RST_ZERO = 16'h0000;
  localparam logic [15:0] PWM_MAX = 16'h00FF;
  localparam int GAIN_SHIFT = 8;
  localparam int PIN_N = 6;
  localparam int P_ENA = 0;
  localparam int P_ENB = 1;
  localparam int P_REF = 2;
  localparam int P_ENDL = 3;
  localparam int P_ENDR = 4;
  localparam int P_LOCK = 5;

  typedef enum logic [2:0] {
    MODE_OFF = 3'h0, MODE_MANUAL = 3'h1, MODE_CENTER = 3'h2,
    MODE_AUTO = 3'h3, MODE_PARK = 3'h4, MODE_SEARCH = 3'h5
  } wgamc_mode_e;
  typedef enum logic [1:0] {
    STR_PROP = 2'h0, STR_BEAM = 2'h1, STR_INTEG = 2'h2
  } wgamc_struct_e;
  typedef enum logic [1:0] {
    OSC_OFF = 2'h0, OSC_SQUARE = 2'h1, OSC_TRIANGLE = 2'h2
  } wgamc_osc_e;
  typedef enum logic [3:0] {
    ST_IDLE, ST_MANUAL, ST_REF_SEEK, ST_CENTER_MOVE, ST_AUTO,
    ST_LOCKED, ST_PARK, ST_SEARCH, ST_TRACK
  } wgamc_state_e;

  typedef struct packed {
    logic [7:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } wgamc_bus_s;
  typedef struct packed {
    logic signed [15:0] web_pos;
    logic edge_found;
  } wgamc_sensor_s;
  typedef struct packed {
    logic pwm;
    logic dir;
    logic en;
  } wgamc_motor_s;
endpackage : wgamc_pkg

/* File: hdl/wgamc_core.sv */
// Purpose: Mode sequencer and P / PI / PWM cascade for a web guide actuator
// Assumes: Pins asynchronous, sensor word on the core clock
// Notes: Control loop runs once per control period tick
// How it works
// - Manual: move to target, manual speed limit
// - Centre: find reference, zero position, go centre
// - Auto: guide to set position when unlocked
// - Lock acts only in automatic mode
// - Lock closed holds position until opened
// - Signed web offset shifts set position
// - Fixed sensor or two carriages: offset 75%
// - Other beams: offset spans beam range
// - Oscillation added to set position
// - Fixed sensor: oscillation within 75% range
// - Park: drive carriage out to outer end
// - Search edge, then track until the edge is lost
// - Proportional: web error through P gives speed
// - PI speed loop drives PWM stage
// - Beam: sensor signal through P gives speed
// - Beam search modes follow web edge
// - Integral: outer P gives actuator set position
// - Integral: inner P on actuator error
`timescale 1ns/100ps
module wgamc_core #(
  parameter int P_TICK_CYCLES = wgamc_pkg::CTRL_PERIOD_CYC
) (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire wgamc_pkg::wgamc_bus_s i_bus,
  output logic [15:0] o_rdata,
  input wire logic [wgamc_pkg::PIN_N-1:0] i_pins,
  input wire wgamc_pkg::wgamc_sensor_s i_sensor,
  output wgamc_pkg::wgamc_motor_s o_motor
);
  import wgamc_pkg::*;

  typedef struct packed {
    logic [PIN_N-1:0] s1;
    logic [PIN_N-1:0] s2;
    logic [PIN_N-1:0] s3;
    logic [PIN_N-1:0] filt;
    logic [15:0] ctrl;
    logic signed [15:0] setpos;
    logic signed [15:0] manpos;
    logic [15:0] manspd;
    logic [15:0] autspd;
    logic signed [15:0] srcspd;
    logic signed [15:0] center;
    logic signed [15:0] offset;
    logic [15:0] oscpth;
    logic [15:0] oscper;
    logic [15:0] snsrng;
    logic [15:0] beamrng;
    logic [15:0] kppos;
    logic [15:0] kpspd;
    logic [15:0] kispd;
    logic [15:0] kpact;
    wgamc_state_e st;
    logic referenced;
    logic signed [15:0] pos;
    logic signed [15:0] pos_prev;
    logic signed [15:0] speed;
    logic signed [15:0] integ;
    logic signed [15:0] drive;
    logic [15:0] tick_cnt;
    logic [15:0] osc_div;
    logic signed [15:0] osc_val;
    logic osc_up;
    logic [7:0] pwm_cnt;
    logic [15:0] rdata;
    wgamc_motor_s motor;
  } wgamc_reg_s;

  wgamc_reg_s q;
  wgamc_reg_s next_q;

  // Clamp to +/- lim, lim taken as a positive magnitude
  function automatic logic signed [15:0] wgamc_sat(
    input logic signed [31:0] v,
    input logic [15:0] lim
  );
    logic signed [31:0] l;
    l = {17'h00000, lim[14:0]};
    if (v > l) begin
      return l[15:0];
    end else if (v < -l) begin
      return 16'(-l);
    end
    return v[15:0];
  endfunction : wgamc_sat

  // Gain in 8.8 fixed point
  function automatic logic signed [31:0] wgamc_gain(
    input logic signed [15:0] e,
    input logic [15:0] k
  );
    logic signed [31:0] p;
    p = 32'(e) * $signed({16'h0000, k});
    return p >>> GAIN_SHIFT;
  endfunction : wgamc_gain

  always_comb begin
    logic signed [15:0] delta;
    logic [PIN_N-1:0] f;
    logic tick;
    logic [15:0] r75;
    logic [15:0] off_lim;
    logic [15:0] osc_lim;
    logic signed [15:0] off_c;
    logic signed [15:0] osc_c;
    logic signed [15:0] shift;
    logic signed [15:0] set_eff;
    logic signed [15:0] web_err;
    logic signed [15:0] act_set;
    logic signed [15:0] sp;
    logic signed [15:0] spd;
    logic signed [15:0] serr;
    logic signed [15:0] amp;
    logic run_osc;
    delta = 16'h0000;
    f = q.filt;
    tick = 1'b0;
    r75 = 16'h0000;
    off_lim = 16'h0000;
    osc_lim = 16'h0000;
    off_c = 16'h0000;
    osc_c = 16'h0000;
    shift = 16'h0000;
    set_eff = 16'h0000;
    web_err = 16'h0000;
    act_set = 16'h0000;
    sp = 16'h0000;
    spd = 16'h0000;
    serr = 16'h0000;
    amp = 16'h0000;
    run_osc = 1'b0;
    next_q = q;
    next_q.rdata = 16'h0000;

    // Three-stage pin sampling; a change counts once stages 2 and 3 agree
    next_q.s1 = i_pins;
    next_q.s2 = q.s1;
    next_q.s3 = q.s2;
    for (int i = 0; i < PIN_N; i++) begin
      if (q.s2[i] == q.s3[i]) begin
        f[i] = q.s3[i];
      end
    end
    next_q.filt = f;

    // Quadrature decode, 00-01-11-10 counts up
    unique case ({q.filt[P_ENA], q.filt[P_ENB], f[P_ENA], f[P_ENB]})
      4'h1, 4'h7, 4'hE, 4'h8: delta = 16'h0001;
      4'h2, 4'hB, 4'hD, 4'h4: delta = 16'hFFFF;
      default: delta = 16'h0000;
    endcase
    next_q.pos = q.pos + delta;

    next_q.pwm_cnt = q.pwm_cnt + 8'h01;
    if (q.tick_cnt >= 16'(P_TICK_CYCLES - 1)) begin
      next_q.tick_cnt = 16'h0000;
      tick = 1'b1;
    end else begin
      next_q.tick_cnt = q.tick_cnt + 16'h0001;
    end

    // Offset and oscillation limits
    r75 = q.snsrng - {2'b00, q.snsrng[15:2]};
    off_lim = (q.ctrl[F_FIXED] || q.ctrl[F_TWOCAR]) ? r75 : q.beamrng;
    osc_lim = q.ctrl[F_FIXED] ? r75 : q.beamrng;
    off_c = wgamc_sat(32'(q.offset), off_lim);
    osc_c = wgamc_sat(32'(q.osc_val), osc_lim);
    shift = wgamc_sat(32'(off_c) + 32'(osc_c), off_lim);
    if (q.ctrl[F_FIXED]) begin
      shift = wgamc_sat(32'(off_c) + 32'(osc_c), r75);
    end
    set_eff = wgamc_sat(32'(q.setpos) + 32'(shift), 16'h7FFF);
    web_err = wgamc_sat(32'(set_eff) - 32'(i_sensor.web_pos), 16'h7FFF);

    // Sequencer
    unique case (q.st)
      ST_IDLE: begin
        sp = 16'h0000;
      end
      ST_MANUAL: begin
        sp = wgamc_sat(wgamc_gain(wgamc_sat(32'(q.manpos) - 32'(q.pos), 16'h7FFF),
          q.kpact), q.manspd);
      end
      ST_REF_SEEK: begin
        // Seek left; bounce off the left end if the switch lies right
        sp = q.referenced ? q.manspd[15:0] : 16'(-$signed(q.manspd));
        if (f[P_ENDL]) begin
          next_q.referenced = 1'b1;
        end
        if (f[P_REF]) begin
          next_q.pos = 16'h0000;
          next_q.referenced = 1'b1;
          next_q.st = ST_CENTER_MOVE;
        end
      end
      ST_CENTER_MOVE: begin
        sp = wgamc_sat(wgamc_gain(wgamc_sat(32'(q.center) - 32'(q.pos), 16'h7FFF),
          q.kpact), q.manspd);
      end
      ST_AUTO: begin
        run_osc = 1'b1;
        if (f[P_LOCK]) begin
          next_q.st = ST_LOCKED;
        end
        unique case (wgamc_struct_e'(q.ctrl[F_STRUCT +: 2]))
          STR_INTEG: begin
            act_set = wgamc_sat(wgamc_gain(web_err, q.kppos), q.beamrng);
            sp = wgamc_sat(wgamc_gain(wgamc_sat(32'(act_set) - 32'(q.pos), 16'h7FFF),
              q.kpact), q.autspd);
          end
          STR_BEAM: begin
            sp = wgamc_sat(wgamc_gain(web_err, q.kppos), q.autspd);
          end
          default: begin
            sp = wgamc_sat(wgamc_gain(web_err, q.kppos), q.autspd);
          end
        endcase
      end
      ST_LOCKED: begin
        // Zero speed demand holds the actuator where it stands
        sp = 16'h0000;
        if (!f[P_LOCK]) begin
          next_q.st = ST_AUTO;
        end
      end
      ST_PARK: begin
        amp = wgamc_sat(32'(q.srcspd), 16'h7FFF);
        sp = amp[15] ? 16'(-amp) : amp;
      end
      ST_SEARCH: begin
        sp = wgamc_sat(32'(q.srcspd), 16'h7FFF);
        if (i_sensor.edge_found) begin
          next_q.st = ST_TRACK;
        end
      end
      ST_TRACK: begin
        // Web error against the offset set position keeps the head on the edge
        sp = wgamc_sat(wgamc_gain(web_err, q.kppos), q.srcspd[15] ?
          16'(-q.srcspd) : q.srcspd);
        if (!i_sensor.edge_found) begin
          next_q.st = ST_SEARCH;
        end
      end
      default: begin
        next_q.st = ST_IDLE;
      end
    endcase

    // End positions block motion toward them only
    if ((f[P_ENDR] && sp > 0) || (f[P_ENDL] && sp < 0)) begin
      sp = 16'h0000;
    end

    // Control period: speed estimate, PI, duty update
    if (tick) begin
      spd = q.pos - q.pos_prev;
      next_q.pos_prev = q.pos;
      next_q.speed = spd;
      serr = wgamc_sat(32'(sp) - 32'(spd), 16'h7FFF);
      if (q.st == ST_IDLE) begin
        next_q.integ = 16'h0000;
        next_q.drive = 16'h0000;
      end else begin
        next_q.integ = wgamc_sat(32'(q.integ) + wgamc_gain(serr, q.kispd),
          PWM_MAX);
        next_q.drive = wgamc_sat(wgamc_gain(serr, q.kpspd) + 32'(q.integ),
          PWM_MAX);
      end
      // Oscillation generator, frozen while locked or outside auto
      if (run_osc && !f[P_LOCK]) begin
        next_q.osc_div = q.osc_div + 16'h0001;
        unique case (wgamc_osc_e'(q.ctrl[F_OSC +: 2]))
          OSC_SQUARE: begin
            if (q.osc_div >= q.oscper) begin
              next_q.osc_div = 16'h0000;
              next_q.osc_up = !q.osc_up;
            end
            next_q.osc_val = q.osc_up ? q.oscpth : 16'(-$signed(q.oscpth));
          end
          OSC_TRIANGLE: begin
            if (q.osc_div >= q.oscper) begin
              next_q.osc_div = 16'h0000;
              next_q.osc_val = q.osc_up ? q.osc_val + 16'h0001 : q.osc_val - 16'h0001;
              if (q.osc_up && q.osc_val >= $signed(q.oscpth)) begin
                next_q.osc_up = 1'b0;
              end
              if (!q.osc_up && q.osc_val <= -$signed(q.oscpth)) begin
                next_q.osc_up = 1'b1;
              end
            end
          end
          default: begin
            next_q.osc_val = 16'h0000;
            next_q.osc_div = 16'h0000;
          end
        endcase
      end
    end

    // Pulse-width stage; hard stop at an end regardless of the loop
    amp = q.drive[15] ? 16'(-q.drive) : q.drive;
    next_q.motor.dir = q.drive[15];
    next_q.motor.en = (q.st != ST_IDLE);
    next_q.motor.pwm = ({8'h00, q.pwm_cnt} < amp) &&
      !(f[P_ENDR] && !q.drive[15]) && !(f[P_ENDL] && q.drive[15]);

    // Register writes
    if (i_bus.wr) begin
      unique case (i_bus.addr)
        A_CTRL: begin
          next_q.ctrl = i_bus.wdata;
          next_q.integ = 16'h0000;
          next_q.osc_val = 16'h0000;
          next_q.osc_div = 16'h0000;
          unique case (wgamc_mode_e'(i_bus.wdata[F_MODE +: 3]))
            MODE_MANUAL: next_q.st = ST_MANUAL;
            MODE_CENTER: begin
              next_q.st = ST_REF_SEEK;
              next_q.referenced = 1'b0;
            end
            MODE_AUTO: next_q.st = f[P_LOCK] ? ST_LOCKED : ST_AUTO;
            MODE_PARK: next_q.st = ST_PARK;
            MODE_SEARCH: next_q.st = ST_SEARCH;
            default: next_q.st = ST_IDLE;
          endcase
        end
        A_SETPOS: next_q.setpos = i_bus.wdata;
        A_MANPOS: next_q.manpos = i_bus.wdata;
        A_MANSPD: next_q.manspd = i_bus.wdata;
        A_AUTSPD: next_q.autspd = i_bus.wdata;
        A_SRCSPD: next_q.srcspd = i_bus.wdata;
        A_CENTER: next_q.center = i_bus.wdata;
        A_OFFSET: next_q.offset = i_bus.wdata;
        A_OSCPTH: next_q.oscpth = i_bus.wdata;
        A_OSCPER: next_q.oscper = i_bus.wdata;
        A_SNSRNG: next_q.snsrng = i_bus.wdata;
        A_BEAMRNG: next_q.beamrng = i_bus.wdata;
        A_KPPOS: next_q.kppos = i_bus.wdata;
        A_KPSPD: next_q.kpspd = i_bus.wdata;
        A_KISPD: next_q.kispd = i_bus.wdata;
        A_KPACT: next_q.kpact = i_bus.wdata;
        default: begin
        end
      endcase
    end

    // Register reads; data stands for one cycle only
    if (i_bus.rd) begin
      unique case (i_bus.addr)
        A_CTRL: next_q.rdata = q.ctrl;
        A_SETPOS: next_q.rdata = q.setpos;
        A_MANPOS: next_q.rdata = q.manpos;
        A_MANSPD: next_q.rdata = q.manspd;
        A_AUTSPD: next_q.rdata = q.autspd;
        A_SRCSPD: next_q.rdata = q.srcspd;
        A_CENTER: next_q.rdata = q.center;
        A_OFFSET: next_q.rdata = q.offset;
        A_OSCPTH: next_q.rdata = q.oscpth;
        A_OSCPER: next_q.rdata = q.oscper;
        A_SNSRNG: next_q.rdata = q.snsrng;
        A_BEAMRNG: next_q.rdata = q.beamrng;
        A_KPPOS: next_q.rdata = q.kppos;
        A_KPSPD: next_q.rdata = q.kpspd;
        A_KISPD: next_q.rdata = q.kispd;
        A_KPACT: next_q.rdata = q.kpact;
        A_STATUS: next_q.rdata = {6'h00, i_sensor.edge_found, q.referenced,
          q.filt[P_ENDR], q.filt[P_ENDL], q.filt[P_REF], q.filt[P_LOCK], q.st};
        A_ACTPOS: next_q.rdata = q.pos;
        A_ACTSPD: next_q.rdata = q.speed;
        default: next_q.rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      q <= '0;
      q.st <= ST_IDLE;
      q.manspd <= RST_SPEED;
      q.autspd <= RST_SPEED;
      q.srcspd <= RST_SPEED;
      q.snsrng <= RST_RANGE;
      q.beamrng <= RST_RANGE;
      q.kppos <= RST_GAIN;
      q.kpspd <= RST_GAIN;
      q.kispd <= RST_ZERO;
      q.kpact <= RST_GAIN;
    end else if (i_ce) begin
      q <= next_q;
    end
  end

  assign o_rdata = q.rdata;
  assign o_motor = q.motor;
endmodule : wgamc_core

/* File: dv/wgamc_core_sva.sv */
// Purpose: Port-level checker for the actuator mode control core
// Assumes: Bound to wgamc_core, single core clock domain
// Notes: Mode is shadowed from CTRL writes; pin rules allow for the pin synchroniser
`timescale 1ns/100ps
module wgamc_core_sva
  import wgamc_pkg::*;
#(
  parameter int P_TICK_CYCLES = wgamc_pkg::CTRL_PERIOD_CYC
) (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire wgamc_pkg::wgamc_bus_s i_bus,
  input wire logic [15:0] o_rdata,
  input wire logic [wgamc_pkg::PIN_N-1:0] i_pins,
  input wire wgamc_pkg::wgamc_sensor_s i_sensor,
  input wire wgamc_pkg::wgamc_motor_s o_motor
);
  import wgamc_pkg::*;
  // Old drive may linger until two control ticks have passed
  localparam int SETTLE = 2 * P_TICK_CYCLES + 8;
  logic [2:0] mode_q;
  int age;
  int endr_age;
  logic ctrl_wr;
  assign ctrl_wr = i_ce && i_bus.wr && (i_bus.addr == A_CTRL);
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      mode_q <= 3'h0;
      age <= 0;
    end else if (ctrl_wr) begin
      mode_q <= i_bus.wdata[2:0];
      age <= 0;
    end else if (i_ce && age < SETTLE) begin
      age <= age + 1;
    end
  end
  // A PI brake pulse off the right end is legal, so park is judged away from it
  always_ff @(posedge i_core_clk) begin
    if (i_rst || i_pins[P_ENDR]) begin
      endr_age <= 0;
    end else if (i_ce && endr_age < SETTLE) begin
      endr_age <= endr_age + 1;
    end
  end
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  sequence s_endl;
    i_pins[P_ENDL] [*6];
  endsequence
  sequence s_endr;
    i_pins[P_ENDR] [*6];
  endsequence
  property p_reset_quiet;
    disable iff (1'b0) i_rst |=> (o_rdata == 16'h0000) && (o_motor == '0);
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("outputs not quiet after reset");
  property p_rdata_idle;
    i_ce && !i_bus.rd |=> o_rdata == 16'h0000;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read slot");
  property p_ce_freeze;
    !i_ce |=> $stable(o_rdata) && $stable(o_motor);
  endproperty
  a_ce_freeze: assert property (p_ce_freeze) else $error("outputs moved with enable low");
  property p_en_mode;
    ctrl_wr ##1 i_ce [*2] |-> o_motor.en == (mode_q != 3'h0 && mode_q <= 3'h5);
  endproperty
  a_en_mode: assert property (p_en_mode) else $error("stage enable does not follow mode");
  property p_off_quiet;
    mode_q == MODE_OFF && age >= SETTLE |-> !o_motor.pwm && !o_motor.en;
  endproperty
  a_off_quiet: assert property (p_off_quiet) else $error("drive active in off mode");
  property p_endl_stop;
    s_endl |-> !(o_motor.pwm && o_motor.dir);
  endproperty
  a_endl_stop: assert property (p_endl_stop) else $error("drive into left end");
  property p_endr_stop;
    s_endr |-> !(o_motor.pwm && !o_motor.dir);
  endproperty
  a_endr_stop: assert property (p_endr_stop) else $error("drive into right end");
  property p_park_right;
    mode_q == MODE_PARK && age >= SETTLE && endr_age >= SETTLE && o_motor.pwm |-> !o_motor.dir;
  endproperty
  a_park_right: assert property (p_park_right) else $error("park moving inward");
  c_park: cover property (mode_q == MODE_PARK && o_motor.pwm);
  c_endr: cover property (i_pins[P_ENDR] && o_motor.en);
  c_lock: cover property (mode_q == MODE_AUTO && i_pins[P_LOCK]);
endmodule : wgamc_core_sva

bind wgamc_core wgamc_core_sva #(.P_TICK_CYCLES(P_TICK_CYCLES)) u_sva (.i_core_clk(i_core_clk),
  .i_rst(i_rst), .i_ce(i_ce), .i_bus(i_bus), .o_rdata(o_rdata), .i_pins(i_pins),
  .i_sensor(i_sensor), .o_motor(o_motor));

/* File: dv/wgamc_motor_model.sv */
// Purpose: Behavioural DC actuator with quadrature encoder and switches
// Assumes: One encoder count per STEP_PWM cycles of active PWM
// Notes: Travel stops hard at both mechanical ends, as a real spindle would
`timescale 1ns/100ps
module wgamc_motor_model #(
  parameter int STEP_PWM = 4,
  parameter int REF_LO = 60,
  parameter int REF_HI = 63,
  parameter int END_R = 200
) (
  input wire logic i_core_clk,
  input wire wgamc_pkg::wgamc_motor_s i_motor,
  output logic [4:0] o_pins
);
  import wgamc_pkg::*;
  int pos = 100;
  int pmin = 100;
  int acc = 0;
  always @(posedge i_core_clk) begin
    pmin <= (pos < pmin) ? pos : pmin;
    if (i_motor.en && i_motor.pwm) begin
      acc <= (acc == STEP_PWM - 1) ? 0 : acc + 1;
      if (acc == STEP_PWM - 1 && i_motor.dir && pos > 0) begin
        pos <= pos - 1;
      end else if (acc == STEP_PWM - 1 && !i_motor.dir && pos < END_R) begin
        pos <= pos + 1;
      end
    end
  end
  // Gray order A,B: 00 01 11 10 while counting up, as the decoder expects
  assign o_pins = {pos >= END_R, pos <= 0, pos >= REF_LO && pos <= REF_HI, pos[1] ^ pos[0], pos[1]};
endmodule : wgamc_motor_model

/* File: dv/wgamc_core_bench.sv */
// Purpose: Self-checking bench for the actuator mode control core
// Assumes: Short control tick, motor model on the pins, sensor word from the bench
// Notes: Guiding cases judged by which PWM directions appear in a window
`timescale 1ns/100ps
module wgamc_core_bench;
  import wgamc_pkg::*;
  localparam int TICK = 16;
  localparam int LIMIT = 30000;
  typedef struct packed {
    logic [15:0] c;
    logic [15:0] off;
    logic [15:0] path;
    logic [15:0] web;
    logic [1:0] e;
  } wgamc_case_s;
  localparam wgamc_case_s CASES [8] = '{'{16'h0003, 16'h0000, 16'h0000, 16'hFF9C, 2'b01},
    '{16'h0003, 16'hFF38, 16'h0000, 16'hFF9C, 2'b10}, '{16'h0023, 16'hFF38, 16'h0000, 16'hFFC4, 2'b01},
    '{16'h00A3, 16'h0000, 16'h00C8, 16'hFFC4, 2'b01}, '{16'h0083, 16'h0000, 16'h00C8, 16'h0000, 2'b11},
    '{16'h004B, 16'hFF38, 16'h0000, 16'hFFC4, 2'b01}, '{16'h000B, 16'hFF38, 16'h0000, 16'hFFC4, 2'b10},
    '{16'h0013, 16'h0000, 16'h0000, 16'hFE0C, 2'b01}};
  localparam logic [7:0] RA [6] = '{A_MANSPD, A_SNSRNG, A_KPPOS, A_KISPD, A_CTRL, 8'hFC};
  localparam logic [15:0] RV [6] = '{RST_SPEED, RST_RANGE, RST_GAIN, RST_ZERO, RST_ZERO, RST_ZERO};
  localparam logic [15:0] MT [2] = '{16'h0014, 16'hFFF8};
  logic i_core_clk = 1'b0;
  logic i_rst = 1'b1;
  logic i_ce = 1'b1;
  logic lock = 1'b0;
  wgamc_bus_s bus = '0;
  wgamc_sensor_s sensor = '0;
  logic [15:0] o_rdata;
  wgamc_motor_s o_motor;
  logic [4:0] mpins;
  logic [15:0] rv;
  logic [15:0] base;
  int mismatches = 0;
  int total_checks = 0;
  int cycles = 0;
  int hi_l = 0;
  int hi_r = 0;
  int nl;
  int nr;
  wgamc_core #(.P_TICK_CYCLES(TICK)) DUT (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_ce(i_ce),
    .i_bus(bus), .o_rdata(o_rdata), .i_pins({lock, mpins}), .i_sensor(sensor), .o_motor(o_motor));
  wgamc_motor_model u_motor (.i_core_clk(i_core_clk), .i_motor(o_motor), .o_pins(mpins));
  initial begin
    forever #20 i_core_clk = ~i_core_clk;
  end
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : give_verdict
  always @(posedge i_core_clk) begin
    cycles <= cycles + 1;
    if (o_motor.pwm && o_motor.dir) hi_l <= hi_l + 1;
    if (o_motor.pwm && !o_motor.dir) hi_r <= hi_r + 1;
    if (cycles == LIMIT) begin
      mismatches++;
      $display("[ERR] run length expected below %0d seen %0d", LIMIT, cycles);
      give_verdict();
    end
  end
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge i_core_clk);
  endtask : wait_cyc
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge i_core_clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge i_core_clk);
    bus.wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge i_core_clk);
    bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge i_core_clk);
    bus.rd <= 1'b0;
    #1 d = o_rdata;
  endtask : rd
  task automatic stat(input logic [3:0] s);
    rd(A_STATUS, rv);
    check("state", {12'h000, rv[3:0]}, {12'h000, s});
  endtask : stat
  task automatic near(input logic [15:0] seen, input logic [15:0] exp);
    int d;
    d = int'($signed(seen)) - int'($signed(exp));
    check("position", {15'h0000, d >= -4 && d <= 4}, 16'h0001);
  endtask : near
  initial begin
    repeat (20) @(posedge i_core_clk);
    i_rst <= 1'b0;
    for (int k = 0; k < 6; k++) begin
      rd(RA[k], rv);
      check("reset value", rv, RV[k]);
    end
    wr(A_SETPOS, 16'h0123);
    rd(A_SETPOS, rv);
    check("setpos", rv, 16'h0123);
    @(posedge i_core_clk);
    i_ce <= 1'b0;
    rd(A_MANSPD, rv);
    check("lost read", rv, 16'h0000);
    @(posedge i_core_clk);
    i_ce <= 1'b1;
    $display("test registers done");
    wr(A_MANSPD, 16'h0000);
    wr(A_MANPOS, 16'h0014);
    wr(A_CTRL, 16'h0001);
    wait_cyc(1000);
    rd(A_ACTPOS, rv);
    check("still", rv, 16'h0000);
    wr(A_MANSPD, RST_SPEED);
    for (int k = 0; k < 2; k++) begin
      wr(A_MANPOS, MT[k]);
      wr(A_CTRL, 16'h0001);
      wait_cyc(3000);
      wr(A_CTRL, 16'h0000);
      wait_cyc(20);
      rd(A_ACTPOS, rv);
      near(rv, MT[k]);
      check("count", rv, 16'(u_motor.pos - 100));
    end
    $display("test manual done");
    @(posedge i_core_clk);
    lock <= 1'b1;
    wr(A_CTRL, 16'h0001);
    wait_cyc(20);
    stat(4'h1);
    wr(A_SETPOS, 16'h0000);
    wr(A_CTRL, 16'h0003);
    wait_cyc(20);
    stat(4'h5);
    rd(A_ACTPOS, base);
    wait_cyc(500);
    rd(A_ACTPOS, rv);
    check("held", rv, base);
    @(posedge i_core_clk);
    lock <= 1'b0;
    wait_cyc(20);
    stat(4'h4);
    $display("test lock done");
    wr(A_CENTER, 16'h0010);
    wr(A_CTRL, 16'h0002);
    wait_cyc(3000);
    stat(4'h3);
    check("referenced", {15'h0000, rv[8]}, 16'h0001);
    check("ref reached", {15'h0000, u_motor.pmin <= 63}, 16'h0001);
    rd(A_ACTPOS, rv);
    near(rv, 16'h0010);
    $display("test centre done");
    wr(A_SNSRNG, 16'h0040);
    wr(A_OSCPER, 16'h0000);
    for (int k = 0; k < 8; k++) begin
      wr(A_OFFSET, CASES[k].off);
      wr(A_OSCPTH, CASES[k].path);
      sensor.web_pos <= CASES[k].web;
      wr(A_CTRL, CASES[k].c);
      wait_cyc(40);
      nl = hi_l;
      nr = hi_r;
      // Longer than one PWM frame, so even a small duty shows its direction
      wait_cyc(260);
      rv = {14'h0000, hi_l > nl, hi_r > nr};
      check("dir", rv, {14'h0000, CASES[k].e});
    end
    $display("test guiding done");
    wr(A_CTRL, 16'h000C);
    wait_cyc(1000);
    stat(4'h6);
    check("right end", {15'h0000, rv[7]}, 16'h0001);
    wr(A_MANPOS, 16'hFE00);
    wr(A_CTRL, 16'h0001);
    wait_cyc(1500);
    rd(A_STATUS, rv);
    check("left end", {15'h0000, rv[6]}, 16'h0001);
    $display("test park done");
    wr(A_CTRL, 16'h000D);
    wait_cyc(40);
    stat(4'h7);
    @(posedge i_core_clk);
    sensor.edge_found <= 1'b1;
    wait_cyc(40);
    stat(4'h8);
    @(posedge i_core_clk);
    sensor.edge_found <= 1'b0;
    wait_cyc(40);
    stat(4'h7);
    wr(A_CTRL, 16'h0003);
    wait_cyc(20);
    stat(4'h4);
    $display("test search done");
    give_verdict();
  end
endmodule : wgamc_core_bench
